//--- hdl/rps_receiver_power_sequencer.sv
`timescale 1ns/1ps
module rps_receiver_power_sequencer #(
   parameter int UNIT_CYCLES = rps_pkg::UNIT_CYC,
   parameter int WINDOW_CYCLES = rps_pkg::WINDOW_CYC
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic auto_warmup_i,
   input wire logic shutdown_req_i,
   input wire logic sync_found_i,
   input wire logic rate_3200_i,
   input wire logic low_battery_input_i,
   input wire logic rx_line0_i,
   input wire logic demod_symbol_in0_i,
   input wire logic demod_symbol_in1_i,
   output logic [7:0] rx_ctrl_lines_o,
   output logic [7:0] rx_ctrl_lines_oe_o,
   output logic slicer_fast_track_o,
   output logic demod_line_o,
   output logic [1:0] symbols_o,
   output logic symbols_valid_o,
   output logic status_report_o
);

   rps_pkg::rps_set_t set_r [rps_pkg::NUM_SET];
   rps_pkg::rps_state_t state_r;
   rps_pkg::rps_step_t step_nxt;
   logic [3:0] idx_r;
   logic [15:0] cnt_r;
   logic [31:0] win_r;
   logic [31:0] tick_cnt_r;
   logic tick;
   logic expire;
   logic enable_r, enable_prev_r, ide_r, ever_on_r;
   logic noise_req_r, aword_req_r;
   logic [7:0] force_r;
   logic host_aword_r, auto_r;
   logic lob_s1_r, lob_s2_r, line0_s1_r, line0_s2_r;
   logic [1:0] sym_s1_r, sym_s2_r;
   logic lb_r, lbu_r, lb_have_r;
   logic leave, poll_hit;
   logic acc, wr, rd, set_hit, status_rd;
   logic [3:0] set_sel;
   logic [31:0] rdata;
   logic rd_err;

   // APB: one wait state, decode on the access phase
   assign acc = psel_i && penable_i && pready_o;
   assign wr = acc && pwrite_i;
   assign rd = acc && !pwrite_i;
   assign set_hit = (paddr_i >= rps_pkg::ADDR_SET_BASE) && (paddr_i <= rps_pkg::ADDR_SET_LAST)
      && (paddr_i[1:0] == 2'h0);
   assign set_sel = 4'((paddr_i - rps_pkg::ADDR_SET_BASE) >> 2);
   assign status_rd = rd && (paddr_i == rps_pkg::ADDR_STATUS);

   always_comb begin
      rdata = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr_i == rps_pkg::ADDR_CTRL) begin
         rdata[rps_pkg::CTRL_ENABLE] = enable_r;
         rdata[rps_pkg::CTRL_IDE] = ide_r;
      end else if (paddr_i == rps_pkg::ADDR_FORCE) begin
         rdata[7:0] = force_r;
      end else if (paddr_i == rps_pkg::ADDR_STATUS) begin
         rdata[rps_pkg::STS_LB_BIT] = lb_r;
         rdata[rps_pkg::STS_LBU_BIT] = lbu_r;
         rdata[rps_pkg::STS_STATE_LSB +: 3] = state_r;
         rdata[rps_pkg::STS_IDX_LSB +: 4] = idx_r;
         rdata[rps_pkg::STS_VALID_BIT] = symbols_valid_o;
      end else if (set_hit) begin
         rdata[rps_pkg::SET_PAT_LSB +: 8] = set_r[set_sel].pat;
         rdata[rps_pkg::SET_POLL_BIT] = set_r[set_sel].poll;
         rdata[rps_pkg::SET_EN_BIT] = set_r[set_sel].en;
         rdata[rps_pkg::SET_DUR_LSB +: 16] = set_r[set_sel].dur;
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && penable_i && !pready_o;
         if (psel_i && penable_i && !pready_o) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rdata;
            pslverr_o <= rd_err;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   // Control and force registers; request bits are one-shot and read as zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_r <= 1'b0;
         ide_r <= 1'b0;
         noise_req_r <= 1'b0;
         aword_req_r <= 1'b0;
         force_r <= 8'h00;
      end else begin
         noise_req_r <= 1'b0;
         aword_req_r <= 1'b0;
         if (wr && paddr_i == rps_pkg::ADDR_CTRL) begin
            enable_r <= pwdata_i[rps_pkg::CTRL_ENABLE];
            ide_r <= pwdata_i[rps_pkg::CTRL_IDE];
            noise_req_r <= pwdata_i[rps_pkg::CTRL_NOISE];
            aword_req_r <= pwdata_i[rps_pkg::CTRL_AWORD];
         end
         if (wr && paddr_i == rps_pkg::ADDR_FORCE) begin
            force_r <= pwdata_i[7:0];
         end
      end
   end

   // Setting table
   for (genvar g = 0; g < rps_pkg::NUM_SET; g++) begin : g_set
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            set_r[g] <= '0;
         end else if (wr && set_hit && set_sel == 4'(g)) begin
            set_r[g].pat <= pwdata_i[rps_pkg::SET_PAT_LSB +: 8];
            set_r[g].poll <= pwdata_i[rps_pkg::SET_POLL_BIT];
            set_r[g].en <= pwdata_i[rps_pkg::SET_EN_BIT];
            set_r[g].dur <= pwdata_i[rps_pkg::SET_DUR_LSB +: 16];
         end
      end
   end

   // Duration timebase
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_cnt_r <= 32'h0000_0000;
      end else if (tick) begin
         tick_cnt_r <= 32'h0000_0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
   end
   assign tick = (tick_cnt_r == 32'(UNIT_CYCLES - 1));
   assign expire = (cnt_r == 16'h0000) || (tick && cnt_r == 16'h0001);

   // Step builders: a disabled entry ends the chain
   function automatic rps_pkg::rps_step_t warm_from(input int k, input logic [3:0] sync_idx,
         input logic [15:0] sync_cnt);
      rps_pkg::rps_step_t s;
      if (k < rps_pkg::NUM_WARM && set_r[4'(k) + rps_pkg::IDX_WU0].en) begin
         s.st = rps_pkg::ST_WARM;
         s.idx = 4'(k) + rps_pkg::IDX_WU0;
         s.cnt = set_r[4'(k) + rps_pkg::IDX_WU0].dur;
      end else begin
         s.st = rps_pkg::ST_SYNC;
         s.idx = sync_idx;
         s.cnt = sync_cnt;
      end
      return s;
   endfunction

   function automatic rps_pkg::rps_step_t shut_from(input int k);
      rps_pkg::rps_step_t s;
      if (k < rps_pkg::NUM_SHUT && set_r[4'(k) + rps_pkg::IDX_SD0].en) begin
         s.st = rps_pkg::ST_SHUT;
         s.idx = 4'(k) + rps_pkg::IDX_SD0;
         s.cnt = set_r[4'(k) + rps_pkg::IDX_SD0].dur;
      end else begin
         s.st = rps_pkg::ST_OFF;
         s.idx = rps_pkg::IDX_OFF;
         s.cnt = 16'h0000;
      end
      return s;
   endfunction

   logic [3:0] auto_sync_idx, host_sync_idx;
   logic [15:0] host_sync_cnt;
   int warm_pos, shut_pos;

   assign auto_sync_idx = rate_3200_i ? rps_pkg::IDX_SY32 : rps_pkg::IDX_SY16;
   // The host path waits the 3200 sync time whichever sync setting it lands on
   assign host_sync_cnt = set_r[rps_pkg::IDX_SY32].dur;
   assign warm_pos = int'(idx_r - rps_pkg::IDX_WU0);
   assign shut_pos = int'(idx_r - rps_pkg::IDX_SD0);

   always_comb begin
      host_sync_idx = host_aword_r ? rps_pkg::IDX_SY16 : rps_pkg::IDX_SY32;
      step_nxt.st = state_r;
      step_nxt.idx = idx_r;
      step_nxt.cnt = (tick && cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
      case (state_r)
         rps_pkg::ST_OFF: begin
            if (enable_r && !enable_prev_r) begin
               step_nxt = warm_from(0, rps_pkg::IDX_SY32, host_sync_cnt);
            end else if (enable_r && noise_req_r) begin
               step_nxt = warm_from(0, rps_pkg::IDX_SY32, host_sync_cnt);
            end else if (enable_r && aword_req_r) begin
               step_nxt = warm_from(0, rps_pkg::IDX_SY16, host_sync_cnt);
            end else if (enable_r && auto_warmup_i) begin
               step_nxt.st = rps_pkg::ST_WOFF;
               step_nxt.idx = rps_pkg::IDX_OFF;
               step_nxt.cnt = set_r[rps_pkg::IDX_OFF].dur;
            end
         end
         rps_pkg::ST_WOFF, rps_pkg::ST_WARM: begin
            if (!enable_r) begin
               step_nxt = shut_from(0);
            end else if (auto_r && win_r == 32'h0000_0001) begin
               step_nxt = shut_from(0);
            end else if (expire) begin
               if (state_r == rps_pkg::ST_WOFF) begin
                  step_nxt = warm_from(0, auto_sync_idx, 16'h0000);
               end else if (auto_r) begin
                  step_nxt = warm_from(warm_pos + 1, auto_sync_idx, 16'h0000);
               end else begin
                  step_nxt = warm_from(warm_pos + 1, host_sync_idx, host_sync_cnt);
               end
            end
         end
         rps_pkg::ST_SYNC, rps_pkg::ST_DATA: begin
            if (!enable_r || shutdown_req_i) begin
               step_nxt = shut_from(0);
            end else if (state_r == rps_pkg::ST_SYNC && sync_found_i) begin
               step_nxt.st = rps_pkg::ST_DATA;
               step_nxt.idx = rate_3200_i ? rps_pkg::IDX_DA32 : rps_pkg::IDX_DA16;
               step_nxt.cnt = 16'h0000;
            end
         end
         rps_pkg::ST_SHUT: begin
            if (expire) begin
               step_nxt = shut_from(shut_pos + 1);
               // Re-enable seen during shut-down warms up when the last shut-down step ends, with no off step
               // Only a fresh enable restarts; a core shut-down request must reach off
               if (step_nxt.st == rps_pkg::ST_OFF && enable_r && !enable_prev_r) begin
                  step_nxt = warm_from(0, rps_pkg::IDX_SY32, host_sync_cnt);
               end
            end
         end
         default: begin
            step_nxt.st = rps_pkg::ST_OFF;
            step_nxt.idx = rps_pkg::IDX_OFF;
            step_nxt.cnt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= rps_pkg::ST_OFF;
         idx_r <= rps_pkg::IDX_OFF;
         cnt_r <= 16'h0000;
         enable_prev_r <= 1'b0;
      end else begin
         state_r <= step_nxt.st;
         idx_r <= step_nxt.idx;
         cnt_r <= step_nxt.cnt;
         // Consumed in off or at the end of shut-down, so an enable during shut-down is not lost
         if (state_r == rps_pkg::ST_OFF || !enable_r
               || (state_r == rps_pkg::ST_SHUT && step_nxt.st != rps_pkg::ST_SHUT)) begin
            enable_prev_r <= enable_r;
         end
      end
   end

   // Warm-up kind and 160 ms window
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         auto_r <= 1'b0;
         host_aword_r <= 1'b0;
         win_r <= 32'h0000_0000;
      end else if (state_r == rps_pkg::ST_OFF || state_r == rps_pkg::ST_SHUT) begin
         auto_r <= step_nxt.st == rps_pkg::ST_WOFF;
         host_aword_r <= aword_req_r && !(enable_r && !enable_prev_r) && !noise_req_r;
         win_r <= 32'(WINDOW_CYCLES);
      end else if (win_r != 32'h0000_0000) begin
         win_r <= win_r - 32'h0000_0001;
      end
   end

   // Synchronisers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lob_s1_r <= 1'b0;
         lob_s2_r <= 1'b0;
         line0_s1_r <= 1'b0;
         line0_s2_r <= 1'b0;
         sym_s1_r <= 2'h0;
         sym_s2_r <= 2'h0;
      end else begin
         lob_s1_r <= low_battery_input_i;
         lob_s2_r <= lob_s1_r;
         line0_s1_r <= rx_line0_i;
         line0_s2_r <= line0_s1_r;
         sym_s1_r <= {demod_symbol_in1_i, demod_symbol_in0_i};
         sym_s2_r <= sym_s1_r;
      end
   end

   // Low battery polling
   assign leave = (step_nxt.idx != idx_r) || (step_nxt.st != state_r);
   assign poll_hit = leave && set_r[idx_r].poll;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lb_r <= 1'b0;
         lb_have_r <= 1'b0;
         lbu_r <= 1'b0;
         status_report_o <= 1'b0;
      end else begin
         status_report_o <= poll_hit && lb_have_r && (lob_s2_r != lb_r);
         if (poll_hit) begin
            lb_r <= lob_s2_r;
            lb_have_r <= 1'b1;
         end
         // A new change wins over a clearing read in the same cycle
         if (poll_hit && lb_have_r && lob_s2_r != lb_r) begin
            lbu_r <= 1'b1;
         end else if (status_rd) begin
            lbu_r <= 1'b0;
         end
      end
   end

   // Pin drive
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ever_on_r <= 1'b0;
         rx_ctrl_lines_o <= 8'h00;
         rx_ctrl_lines_oe_o <= 8'h00;
         slicer_fast_track_o <= 1'b0;
         demod_line_o <= 1'b0;
         symbols_o <= 2'h0;
         symbols_valid_o <= 1'b0;
      end else begin
         if (enable_r) begin
            ever_on_r <= 1'b1;
         end
         rx_ctrl_lines_o <= set_r[step_nxt.idx].pat;
         rx_ctrl_lines_oe_o <= (ever_on_r || enable_r) ? 8'hFF : force_r;
         if (ide_r) begin
            rx_ctrl_lines_oe_o[0] <= 1'b0;
         end
         slicer_fast_track_o <= set_r[step_nxt.idx].pat[0];
         demod_line_o <= ide_r && line0_s2_r;
         symbols_o <= sym_s2_r;
         symbols_valid_o <= (step_nxt.st == rps_pkg::ST_SYNC || step_nxt.st == rps_pkg::ST_DATA)
            && step_nxt.cnt == 16'h0000;
      end
   end

endmodule // rps_receiver_power_sequencer

//--- hdl/rps_pkg.sv
package rps_pkg;

   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_FORCE = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_SET_BASE = 12'h040;
   localparam logic [11:0] ADDR_SET_LAST = 12'h074;

   // Control register bits
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_IDE = 1;
   localparam int CTRL_NOISE = 2;
   localparam int CTRL_AWORD = 3;

   // Setting word layout
   localparam int SET_PAT_LSB = 0;
   localparam int SET_POLL_BIT = 8;
   localparam int SET_EN_BIT = 9;
   localparam int SET_DUR_LSB = 16;

   // Status word layout
   localparam int STS_LB_BIT = 0;
   localparam int STS_LBU_BIT = 1;
   localparam int STS_STATE_LSB = 4;
   localparam int STS_IDX_LSB = 8;
   localparam int STS_VALID_BIT = 12;

   // Setting table indices
   localparam int NUM_SET = 14;
   localparam int NUM_WARM = 6;
   localparam int NUM_SHUT = 3;
   localparam logic [3:0] IDX_OFF = 4'h0;
   localparam logic [3:0] IDX_WU0 = 4'h1;
   localparam logic [3:0] IDX_SD0 = 4'h7;
   localparam logic [3:0] IDX_SY16 = 4'hA;
   localparam logic [3:0] IDX_SY32 = 4'hB;
   localparam logic [3:0] IDX_DA16 = 4'hC;
   localparam logic [3:0] IDX_DA32 = 4'hD;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int UNIT_NS = 100_000;
   localparam int UNIT_CYC = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WINDOW_MS = 160;
   localparam int WINDOW_CYC = WINDOW_MS * 1_000_000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_WOFF = 3'b001,
      ST_WARM = 3'b010,
      ST_SYNC = 3'b011,
      ST_DATA = 3'b100,
      ST_SHUT = 3'b101
   } rps_state_t;

   typedef struct packed {
      logic [15:0] dur;
      logic en;
      logic poll;
      logic [7:0] pat;
   } rps_set_t;

   typedef struct packed {
      rps_state_t st;
      logic [3:0] idx;
      logic [15:0] cnt;
   } rps_step_t;

endpackage

//--- tb/rps_asserts.sv
`timescale 1ns/1ps
module rps_asserts (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [7:0] rx_ctrl_lines_o,
   input wire logic [7:0] rx_ctrl_lines_oe_o,
   input wire logic slicer_fast_track_o,
   input wire logic demod_line_o,
   input wire logic symbols_valid_o,
   input wire logic status_report_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_wait;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_done;
      pready_o ##1 !pready_o;
   endsequence
   a_apb_answer: assert property (s_wait |=> s_done)
      else $error("apb answer late or long");
   a_err_paired: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_float_reset: assert property ($rose(resetn_i) |-> rx_ctrl_lines_oe_o == 8'h00)
      else $error("lines driven after reset");
   a_drive_kept: assert property ((rx_ctrl_lines_oe_o[7:1] == 7'h7F) |=>
      (rx_ctrl_lines_oe_o[7:1] == 7'h7F)) else $error("lines released");
   a_slicer_bit: assert property (slicer_fast_track_o == rx_ctrl_lines_o[0])
      else $error("slicer speed differs from line zero bit");
   a_demod_input: assert property (demod_line_o |-> !rx_ctrl_lines_oe_o[0])
      else $error("line zero driven in demod mode");
   a_valid_driven: assert property (symbols_valid_o |-> rx_ctrl_lines_oe_o[7:1] == 7'h7F)
      else $error("symbols valid while lines float");
   a_report_pulse: assert property (status_report_o |=> !status_report_o)
      else $error("report longer than one cycle");
endmodule // rps_asserts

//--- tb/rps_rx_frontend.sv
`timescale 1ns/1ps
module rps_rx_frontend (
   input wire logic clk_i,
   input wire logic [7:0] lines_i,
   input wire logic [7:0] oe_i,
   input wire logic batt_low_i,
   output logic low_battery_input_o,
   output logic line0_o,
   output logic sym0_o,
   output logic sym1_o
);
   logic [15:0] lf_r = 16'hACE1;
   logic tgl_r = 1'b0;
   logic on;
   // Pull-downs hold undriven lines low
   assign on = |(lines_i & oe_i);
   always_ff @(posedge clk_i) begin
      lf_r <= {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
      tgl_r <= ~tgl_r;
   end
   assign low_battery_input_o = batt_low_i;
   assign line0_o = lf_r[3];
   // A receiver that is off gives a toggling output, never a settled symbol
   assign sym0_o = on ? lf_r[0] : tgl_r;
   assign sym1_o = on ? lf_r[7] : ~tgl_r;
endmodule // rps_rx_frontend

//--- tb/tb_rps_receiver_power_sequencer.sv
`timescale 1ns/1ps
module tb_rps_receiver_power_sequencer;
   localparam int U = 4;
   logic clk_i = 0, resetn_i = 0, psel = 0, pen = 0, pwr = 0, err;
   logic aw = 0, sdr = 0, sf = 0, r32 = 0, batt = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, prdata, seed = 32'h3C24190A, w;
   logic pready, pslverr, fast, dline, sval, rep, low_battery_input, l0, s0, s1;
   logic [7:0] lines, oe;
   logic [1:0] syms;
   int failures = 0, total_checks = 0, reps = 0, n, i;
   always #4 clk_i = ~clk_i;
   always_ff @(posedge clk_i) if (rep === 1'b1) reps <= reps + 1;
   rps_receiver_power_sequencer #(.UNIT_CYCLES(U), .WINDOW_CYCLES(2000)) u_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .auto_warmup_i(aw), .shutdown_req_i(sdr), .sync_found_i(sf),
      .rate_3200_i(r32), .low_battery_input_i(low_battery_input), .rx_line0_i(l0),
      .demod_symbol_in0_i(s0), .demod_symbol_in1_i(s1), .rx_ctrl_lines_o(lines),
      .rx_ctrl_lines_oe_o(oe), .slicer_fast_track_o(fast), .demod_line_o(dline),
      .symbols_o(syms), .symbols_valid_o(sval), .status_report_o(rep));
   rps_rx_frontend u_rx (.clk_i(clk_i), .lines_i(lines), .oe_i(oe), .batt_low_i(batt),
      .low_battery_input_o(low_battery_input), .line0_o(l0), .sym0_o(s0), .sym1_o(s1));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task test_done();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("FAIL %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_i);
      pen <= 1;
      k = 0;
      do begin @(posedge clk_i); k++; end while (pready !== 1'b1 && k < 50);
      chk("pready", 1, pready);
      if (k >= 50) test_done();
      rd = prdata; err = pslverr; psel <= 0; pen <= 0;
   endtask
   task wset(input int x, input logic [7:0] p, input logic pl, input logic en, input int d);
      apb(1, rps_pkg::ADDR_SET_BASE + 12'(4 * x), {d[15:0], 6'h00, en, pl, p});
   endtask
   // Waits for a line pattern; n is how long the previous pattern held
   task wl(input logic [7:0] v, output int c);
      c = 0;
      while (lines !== v && c < 3000) begin @(posedge clk_i); c++; end
      chk("lines", {24'h0, v}, {24'h0, lines});
      if (c >= 3000) test_done();
   endtask
   task pulse(input int k);
      @(posedge clk_i);
      case (k)
         0: aw <= 1;
         1: sdr <= 1;
         default: sf <= 1;
      endcase
      @(posedge clk_i);
      {aw, sdr, sf} <= 3'b000;
   endtask
   task stop();
      pulse(1);
      wl(8'h66, n);
      wl(8'h00, n);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1;
      @(posedge clk_i);
      chk("oe", 0, {24'h0, oe});
      for (i = 0; i < rps_pkg::NUM_SET; i++) begin
         w = xs() & 32'hFFFF03FF;
         apb(1, rps_pkg::ADDR_SET_BASE + 12'(4 * i), w);
         apb(0, rps_pkg::ADDR_SET_BASE + 12'(4 * i), 0);
         chk("setting", w, rd);
      end
      apb(0, 12'h0F0, 0);
      chk("pslverr", 1, err);
      chk("prdata", 0, rd);
      apb(1, rps_pkg::ADDR_FORCE, 32'h05);
      repeat (2) @(posedge clk_i);
      chk("oe", 32'h05, {24'h0, oe});
      wset(0, 8'h00, 0, 1, 2); wset(1, 8'hA1, 1, 1, 3); wset(2, 8'hB2, 0, 1, 2);
      wset(3, 8'h00, 0, 0, 1); wset(7, 8'h66, 1, 1, 2); wset(8, 8'h00, 0, 0, 1);
      wset(10, 8'hC4, 0, 1, 1); wset(11, 8'hD8, 0, 1, 2);
      wset(12, 8'hE3, 0, 1, 1); wset(13, 8'hF5, 0, 1, 1);
      $display("setup done");
      apb(1, rps_pkg::ADDR_CTRL, 32'h1);
      wl(8'hA1, n);
      wl(8'hB2, n);
      chk("dur", 1, n >= 2 * U && n <= 3 * U + 2);
      wl(8'hD8, n);
      chk("valid", 0, sval);
      repeat (2 * U + 3) @(posedge clk_i);
      chk("valid", 1, sval);
      chk("oe", 32'hFF, {24'h0, oe});
      batt <= 1;
      r32 <= 1;
      pulse(2);
      wl(8'hF5, n);
      stop();
      repeat (8) @(posedge clk_i);
      chk("reports", 1, reps);
      apb(0, rps_pkg::ADDR_STATUS, 0);
      chk("status", 3, rd & 3);
      apb(0, rps_pkg::ADDR_STATUS, 0);
      chk("status", 1, rd & 3);
      $display("enable done");
      apb(1, rps_pkg::ADDR_CTRL, 32'h7);
      wl(8'hA1, n);
      chk("oe", 32'hFE, {24'h0, oe});
      wl(8'hB2, n);
      wl(8'hD8, n);
      stop();
      apb(1, rps_pkg::ADDR_CTRL, 32'h9);
      wl(8'hA1, n);
      wl(8'hC4, n);
      r32 <= 0;
      pulse(2);
      wl(8'hE3, n);
      stop();
      $display("requests done");
      pulse(0);
      wl(8'hA1, n);
      chk("off time", 1, n >= U - 2 && n <= 2 * U + 3);
      wl(8'hB2, n);
      wl(8'hC4, n);
      repeat (2) @(posedge clk_i);
      chk("valid", 1, sval);
      apb(1, rps_pkg::ADDR_CTRL, 32'h0);
      wl(8'h66, n);
      apb(1, rps_pkg::ADDR_CTRL, 32'h1);
      wl(8'hA1, n);
      // The re-enabling transfer itself spans four cycles of the shut-down step
      chk("shut held", 1, n + 4 >= U);
      wl(8'hD8, n);
      stop();
      $display("auto done");
      wset(1, 8'hA1, 1, 1, 600);
      pulse(0);
      wl(8'hA1, n);
      wl(8'h66, n);
      chk("window", 1, n > 1900 && n < 2100);
      $display("overrun done");
      test_done();
   end
endmodule // tb_rps_receiver_power_sequencer
bind rps_receiver_power_sequencer rps_asserts u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
   .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .rx_ctrl_lines_o(rx_ctrl_lines_o), .rx_ctrl_lines_oe_o(rx_ctrl_lines_oe_o),
   .slicer_fast_track_o(slicer_fast_track_o), .demod_line_o(demod_line_o),
   .symbols_valid_o(symbols_valid_o), .status_report_o(status_report_o));
